/* gpio_signal_mux_map.vh */
// Register map, field positions, reset values and select codes of the GPIO output multiplexer.
`ifndef GPIO_SIGNAL_MUX_MAP_VH
`define GPIO_SIGNAL_MUX_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_PORT_ENABLE      6'h01
`define IDX_PIN_CONFIG       6'h08
`define IDX_SWEEP_CONTROL    6'h10
`define IDX_PORT_STATUS      6'h11

// Bus geometry.
`define ADDR_WIDTH           8
`define DATA_WIDTH           32
`define PIN_COUNT            5

// Port enable register fields.
`define ENABLE_BIT           4

// Pin configuration register fields.
`define CONFIG_WIDTH         14
`define DIR_MSB              13
`define DIR_LSB              9
`define TEST_MSB             8
`define TEST_LSB             4
`define SELECT_MSB           3
`define SELECT_LSB           0

// Sweep control register fields.
`define SWEEP_MODE_BIT       0

// Port status register fields.
`define STATUS_PIN_MSB       4
`define STATUS_PIN_LSB       0
`define STATUS_TRIG_BIT      8

// Reset values.
`define RESET_ENABLE         1'h0
`define RESET_CONFIG         14'h0000
`define RESET_SWEEP          1'h0

// Output select codes.
`define SEL_TEST             4'h0
`define SEL_MODULATOR        4'h2
`define SEL_LOW_PAIR_ZERO    4'h6
`define SEL_SWEEP_FLAGS      4'h8

// Bus responses.
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

/* gpio_signal_mux.v */
// Five-pin GPIO port with output multiplexer, sweep trigger input and AXI4-Lite register slave.
//
// Operation
// - Pins are driven or sampled only while the port enable bit is set.
// - Each pin has its own direction bit; one means output, zero means input.
// - In sweep mode, highest pin with direction cleared is the sweep trigger input.
// - Select 0000 drives the five test bits onto the pins in pin order.
// - Select 0010 drives the modulator output word, bit n onto pin n.
// - Select 1000 in sweep mode drives ready, start, stop, busy flags on pins 4..1.
// - Select picks the source; 1001-1111 give zero, 0110 zeroes all five pins.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpio_signal_mux_map.vh"

module gpio_signal_mux (
  // Clock and reset.
  input  wire        clock,
  input  wire        srst,
  // AXI4-Lite write address channel.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response channel.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data channel.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Internal sources for the multiplexer.
  input  wire [4:0]  modulatorOutputWord,
  input  wire        rampReadyFlag,
  input  wire        rampStartFlag,
  input  wire        rampStopFlag,
  input  wire        rampBusyFlag,
  // General-purpose pins, split into input, output and output enable.
  input  wire [4:0]  gpioPinIn,
  output reg  [4:0]  gpioPinOut,
  output reg  [4:0]  gpioPinOe,
  // Sweep trigger towards the sweeper.
  output reg         sweepTriggerPulse
);

  // Decodes a byte address into a one-hot register select; bit 4 flags an unmapped address.
  // Misaligned addresses fall into the unmapped slot, so a stray byte access never hits a register.
  function [4:0] decodeAddress;
    input [7:0] byteAddr;
    begin
      decodeAddress = 5'h10;
      if (byteAddr[1:0] == 2'h0) begin
        case (byteAddr[7:2])
          `IDX_PORT_ENABLE:   decodeAddress = 5'h01;
          `IDX_PIN_CONFIG:    decodeAddress = 5'h02;
          `IDX_SWEEP_CONTROL: decodeAddress = 5'h04;
          `IDX_PORT_STATUS:   decodeAddress = 5'h08;
          default:            decodeAddress = 5'h10;
        endcase
      end
    end
  endfunction

  // Merges written bytes into an old word under the byte strobes.
  // Bytes with a low strobe keep their old contents, which lets software touch one byte alone.
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  strobe;
    integer      i;
    begin
      mergeBytes = oldWord;
      for (i = 0; i < 4; i = i + 1) begin
        if (strobe[i]) begin
          mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  // Software-visible state.
  reg         portEnable_reg;
  reg  [13:0] pinConfig_reg;
  reg         sweepMode_reg;

  // Write channel bookkeeping: address and data are held until both have arrived.
  reg  [7:0]  awAddrHeld_reg;
  reg         awHeld_reg;
  reg  [31:0] wDataHeld_reg;
  reg  [3:0]  wStrbHeld_reg;
  reg         wHeld_reg;

  // Pin sampling state.
  reg  [4:0]  pinSample_reg;
  reg         triggerPrev_reg;

  // Field views of the configuration register.
  wire [4:0]  pinDirection = pinConfig_reg[`DIR_MSB:`DIR_LSB];
  wire [4:0]  testValue    = pinConfig_reg[`TEST_MSB:`TEST_LSB];
  wire [3:0]  outputSelect = pinConfig_reg[`SELECT_MSB:`SELECT_LSB];

  // Byte-merged image of a configuration write; only the low fourteen bits are kept.
  wire [31:0] cfgMerged    = mergeBytes({18'h00000, pinConfig_reg}, wDataHeld_reg, wStrbHeld_reg);

  // Pin 4 acts as the trigger only with the port on, sweep mode on and the pin set as input.
  // Gating by the enable keeps a floating pad from starting a sweep while the port is off.
  wire        triggerArmed = portEnable_reg & sweepMode_reg & ~pinDirection[4];

  // Write handshake terms.
  // A write is carried out only once both halves are held and no answer is still pending.
  wire        awTake  = s_axi_awvalid & s_axi_awready;
  wire        wTake   = s_axi_wvalid & s_axi_wready;
  wire        doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire [4:0]  wrSel   = decodeAddress(awAddrHeld_reg);
  wire        bDone   = s_axi_bvalid & s_axi_bready;

  // Read handshake terms.
  // The read address is decoded straight from the bus, since it is used in the cycle it is taken.
  wire        arTake  = s_axi_arvalid & s_axi_arready;
  wire        rDone   = s_axi_rvalid & s_axi_rready;
  wire [4:0]  rdSel   = decodeAddress(s_axi_araddr);

  // Next values of the write channel flags.
  reg         awHeld_next;
  reg         wHeld_next;
  reg         bValid_next;

  // Multiplexer source before direction and enable gating.
  reg  [4:0]  muxSource;

  // Next-state logic of the write channel; ready drops while a word waits or a response is pending.
  // Address and data may come in either order; each half waits in its holding register.
  // Clearing both holds in the write cycle keeps a stale half from being applied twice.
  always @* begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    bValid_next = s_axi_bvalid;
    if (awTake) begin
      awHeld_next = 1'b1;
    end
    if (wTake) begin
      wHeld_next = 1'b1;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
    end else if (bDone) begin
      bValid_next = 1'b0;
    end
  end

  // Write address and data capture with the response channel.
  // The write lands one edge after the later half is taken, and the answer stands from that
  // edge until the master takes it. Ready is registered from the next values, so it never
  // rises in the same cycle as a pending answer; this costs one cycle per write.
  always @(posedge clock) begin
    if (srst) begin
      awAddrHeld_reg <= 8'h00;
      awHeld_reg     <= 1'b0;
      wDataHeld_reg  <= 32'h00000000;
      wStrbHeld_reg  <= 4'h0;
      wHeld_reg      <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `RESP_OKAY;
    end else begin
      awHeld_reg    <= awHeld_next;
      wHeld_reg     <= wHeld_next;
      s_axi_bvalid  <= bValid_next;
      s_axi_awready <= ~awHeld_next & ~bValid_next;
      s_axi_wready  <= ~wHeld_next & ~bValid_next;
      if (awTake) begin
        awAddrHeld_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wDataHeld_reg <= s_axi_wdata;
        wStrbHeld_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bresp <= wrSel[4] ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // Register writes; the status register is read-only and ignores writes with an OKAY answer.
  // Single-bit fields need the low strobe; the configuration merges per byte.
  // The upper bits of the merged word are cut off on purpose, as the register is fourteen bits wide.
  always @(posedge clock) begin
    if (srst) begin
      portEnable_reg <= `RESET_ENABLE;
      pinConfig_reg  <= `RESET_CONFIG;
      sweepMode_reg  <= `RESET_SWEEP;
    end else if (doWrite) begin
      if (wrSel[0] && wStrbHeld_reg[0]) begin
        portEnable_reg <= wDataHeld_reg[`ENABLE_BIT];
      end
      if (wrSel[1]) begin
        pinConfig_reg <= cfgMerged[`DIR_MSB:0];
      end
      if (wrSel[2] && wStrbHeld_reg[0]) begin
        sweepMode_reg <= wDataHeld_reg[`SWEEP_MODE_BIT];
      end
    end
  end

  // Read channel: the answer follows one cycle after the address is taken.
  // Ready returns at the edge that hands the answer over, so back-to-back reads lose one cycle.
  // Read data is latched when the address is taken, so a value that moves later does not
  // tear the word while it waits for the master.
  always @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= rdSel[4] ? `RESP_SLVERR : `RESP_OKAY;
        s_axi_rdata   <= ({32{rdSel[0]}} & {27'h0000000, portEnable_reg, 4'h0})
                       | ({32{rdSel[1]}} & {18'h00000, pinConfig_reg})
                       | ({32{rdSel[2]}} & {31'h00000000, sweepMode_reg})
                       | ({32{rdSel[3]}} & {23'h000000, triggerArmed, 3'h0, pinSample_reg});
      end else if (rDone) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Source selection; reserved codes drive zero so the pins never float to an undefined level.
  // The sweep flags reach the pins only in sweep mode; outside it the code behaves as a zero.
  // Pin 0 has no flag and stays low under the flag code.
  always @* begin
    case (outputSelect)
      `SEL_TEST:          muxSource = testValue;
      `SEL_MODULATOR:     muxSource = modulatorOutputWord;
      `SEL_LOW_PAIR_ZERO: muxSource = 5'h00;
      `SEL_SWEEP_FLAGS:   muxSource = sweepMode_reg ?
                                      {rampReadyFlag, rampStartFlag, rampStopFlag, rampBusyFlag, 1'b0} :
                                      5'h00;
      default:            muxSource = 5'h00;
    endcase
  end

  // Per-pin output drivers; an input pin or a disabled port keeps its driver off.
  // Enable and output value are both registered from the same terms, so they change together
  // and a pad never shows a new value under an old enable. The value is masked by the enable
  // as well, which keeps the output at zero while the pad is released.
  genvar pin;
  generate
    for (pin = 0; pin < `PIN_COUNT; pin = pin + 1) begin : pinDriver
      always @(posedge clock) begin
        if (srst) begin
          gpioPinOut[pin] <= 1'b0;
          gpioPinOe[pin]  <= 1'b0;
        end else begin
          gpioPinOe[pin]  <= portEnable_reg & pinDirection[pin];
          gpioPinOut[pin] <= portEnable_reg & pinDirection[pin] & muxSource[pin];
        end
      end
    end
  endgenerate

  // Input sampling; a disabled port reads zero so a floating pad cannot leak into the status.
  // Output pins read zero, so status shows only what the outside world drives.
  // Inputs are taken as synchronous to the clock; a pad from another domain needs a synchroniser.
  always @(posedge clock) begin
    if (srst) begin
      pinSample_reg <= 5'h00;
    end else begin
      pinSample_reg <= portEnable_reg ? (gpioPinIn & ~pinDirection) : 5'h00;
    end
  end

  // Rising edge of the trigger pin gives one pulse; the edge is taken from sampled levels.
  // Sample and pulse are two register stages, so the pulse follows the pad by two edges.
  // The previous level resets low; since the port resets disabled and unarmed, no pulse can
  // come straight out of reset.
  always @(posedge clock) begin
    if (srst) begin
      triggerPrev_reg   <= 1'b0;
      sweepTriggerPulse <= 1'b0;
    end else begin
      triggerPrev_reg   <= triggerArmed & pinSample_reg[4];
      sweepTriggerPulse <= triggerArmed & pinSample_reg[4] & ~triggerPrev_reg;
    end
  end

endmodule // gpio_signal_mux

/* gpio_signal_mux_checker.sv */
// Concurrent checks on the bus handshakes, pins and sweep trigger of the GPIO multiplexer.
`timescale 1ns/1ps
module gpio_signal_mux_checker (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        srst,
  // Bus handshakes and answers.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  // Pads and trigger.
  input wire logic [4:0]  gpioPinIn,
  input wire logic [4:0]  gpioPinOut,
  input wire logic [4:0]  gpioPinOe,
  input wire logic        sweepTriggerPulse
);
  // One domain, so clock and reset are stated once for every property.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_input_not_driven: assert property ((gpioPinOut & ~gpioPinOe) == 5'h00)
    else $error("pin value driven without its enable");
  a_reset_pins_off: assert property ($past(srst) |-> gpioPinOe == 5'h00)
    else $error("pins enabled straight after reset");
  a_pins_by_write: assert property (!$stable(gpioPinOe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin direction changed without a register write");
  a_trig_on_input: assert property (sweepTriggerPulse |-> !gpioPinOe[4])
    else $error("trigger pulse while highest pin is an output");
  a_trig_one_cycle: assert property (sweepTriggerPulse |=> !sweepTriggerPulse)
    else $error("trigger pulse longer than one cycle");
  a_trig_needs_high: assert property (sweepTriggerPulse |-> $past(gpioPinIn[4], 2))
    else $error("trigger pulse without a high trigger pin");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not offered one cycle after address");
  a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("write response code out of range");
endmodule // gpio_signal_mux_checker

/* gpio_pad_partner.sv */
// Model of the outside logic that faces the five GPIO pads.
`timescale 1ns/1ps
module gpio_pad_partner (
  // Pad drive from the device.
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  // Level the outside logic puts on pads that the device leaves alone.
  input  wire logic [4:0] pattern,
  // Resolved pad level seen by the device.
  output wire logic [4:0] pinIn
);
  // The outside logic yields every pad the device drives, so no pad ever has two drivers.
  assign pinIn = (pinOe & pinOut) | (~pinOe & pattern);
endmodule // gpio_pad_partner

/* gpio_signal_mux_tb_top.sv */
// Self-checking bench for the GPIO multiplexer with random and corner stimulus.
`timescale 1ns/1ps
`include "gpio_signal_mux_map.vh"
module gpio_signal_mux_tb_top;
  localparam logic [7:0] EN = {`IDX_PORT_ENABLE, 2'b00};
  localparam logic [7:0] CFG = {`IDX_PIN_CONFIG, 2'b00};
  localparam logic [7:0] SW = {`IDX_SWEEP_CONTROL, 2'b00};
  localparam logic [7:0] STAT = {`IDX_PORT_STATUS, 2'b00};
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got, cfg, rnd = 32'h42115F53;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sweepTriggerPulse, en, sw;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]  modWord = 5'h00, pattern = 5'h00, gpioPinIn, gpioPinOut, gpioPinOe;
  logic [3:0]  flags = 4'h0, strb = 4'hF;
  int          failCount = 0, nChecks = 0, pulses = 0;

  // Free-running 200 MHz clock.
  always #2.5 clock = ~clock;
  // Trigger pulses are counted here so a scenario can judge how many came out.
  always @(posedge clock) if (sweepTriggerPulse) pulses++;

  gpio_signal_mux dut (.clock(clock), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .modulatorOutputWord(modWord), .rampReadyFlag(flags[3]), .rampStartFlag(flags[2]), .rampStopFlag(flags[1]),
    .rampBusyFlag(flags[0]), .gpioPinIn(gpioPinIn), .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe),
    .sweepTriggerPulse(sweepTriggerPulse));
  gpio_pad_partner pads (.pinOut(gpioPinOut), .pinOe(gpioPinOe), .pattern(pattern), .pinIn(gpioPinIn));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Address and data go out together; each is dropped at the edge that takes it.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (t > 50) begin
        failCount++;
        end_of_test();
      end
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  // The read answer is taken at the edge that shows it valid.
  task automatic axiRead(input logic [7:0] a);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (t > 50) begin
        failCount++;
        end_of_test();
      end
    end while (s_axi_rvalid !== 1'b1);
    got = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected enables and values of the pads, enables in the upper five bits.
  function automatic logic [9:0] expPins(input logic e, input logic s, input logic [13:0] c, input logic [4:0] m,
                                         input logic [3:0] f);
    logic [4:0] src, oe;
    src = c[3:0] == 4'h0 ? c[8:4] : c[3:0] == 4'h2 ? m : (c[3:0] == 4'h8 && s) ? {f, 1'b0} : 5'h00;
    oe = e ? c[13:9] : 5'h00;
    return {oe, oe & src};
  endfunction

  // Reset, register defaults, a refused address, then every select code twice and the trigger.
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(gpioPinOe, 32'h0);
    axiRead(CFG);
    chk(got, 32'h0);
    axiRead(8'h0C);
    chk(resp, `RESP_SLVERR);
    chk(got, 32'h0);
    axiWrite(8'h0C, 32'hFFFFFFFF);
    chk(resp, `RESP_SLVERR);
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      en = i[3:0] != 4'h5;
      sw = i[4];
      cfg = {18'h0, rnd[13:4], i[3:0]};
      modWord <= rnd[18:14];
      flags <= rnd[22:19];
      pattern <= rnd[27:23];
      axiWrite(EN, {27'h0, en, 4'h0});
      axiWrite(SW, {31'h0, sw});
      axiWrite(CFG, cfg);
      chk(resp, `RESP_OKAY);
      repeat (3) @(posedge clock);
      chk({gpioPinOe, gpioPinOut}, expPins(en, sw, cfg[13:0], rnd[18:14], rnd[22:19]));
      axiRead(CFG);
      chk(got, cfg);
      axiRead(STAT);
      chk(got, {23'h0, en & sw & ~cfg[13], 3'h0, en ? rnd[27:23] & ~cfg[13:9] : 5'h00});
    end
    // A rising highest pin gives one pulse in sweep mode and none outside it.
    for (int s = 0; s < 2; s++) begin
      pattern <= 5'h00;
      axiWrite(EN, 32'h10);
      axiWrite(SW, s);
      axiWrite(CFG, 32'h0);
      repeat (4) @(posedge clock);
      pulses = 0;
      pattern <= 5'h10;
      repeat (8) @(posedge clock);
      chk(pulses, s);
    end
    // A reset in mid-run brings registers and pins back to their defaults.
    srst <= 1'b1;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(gpioPinOe, 32'h0);
    axiRead(EN);
    chk(got, 32'h0);
    // With only the low strobe set, only the low byte of the configuration changes.
    strb <= 4'h1;
    axiWrite(CFG, 32'h00003FFF);
    chk(resp, `RESP_OKAY);
    axiRead(CFG);
    chk(got, 32'h000000FF);
    strb <= 4'hF;
    end_of_test();
  end
endmodule // gpio_signal_mux_tb_top

bind gpio_signal_mux gpio_signal_mux_checker chk_i (.clock(clock), .srst(srst), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .gpioPinIn(gpioPinIn), .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe),
  .sweepTriggerPulse(sweepTriggerPulse));
